/* File: hdl/desd_top.sv */
// Dual quadrature encoder speed, direction and fault block.
// Assumes settings come from core_clk_i logic and encoder pins are async.
// Behaviour
// - Without swap, B low at a rising A edge means forward, B high reverse.
// - Each channel has its own swap that reverses the meaning of B.
// - Two independent encoder inputs exist, each with its own A and B.
// - With encoders fitted, a faulty encoder, or a missing one while speed demand is non-zero, raises an error.
// - With encoders not fitted, no encoder error is ever raised.
// - During an encoder error the speed is capped at a 0 to 100 % limit.
// - Resolution of 1 to 128 pulses per revolution scales counts to rpm.
// - Rated motor speed is accepted from 150 to 9775 rpm.
// - Full target speed is 21.6/24 of rated speed times the speed cap.
// - Compensation 0 to 500 milliohms in 5 milliohm steps is held.
`timescale 1ns/100ps
module desd_top #(
    parameter int unsigned MEAS_CYCLES = desd_pkg::MEAS_CYCLES
) (
    input  logic                        core_clk_i,
    input  logic                        sys_rst_i,
    input  logic                        first_motor_channel_a_i,
    input  logic                        first_motor_channel_b_i,
    input  logic                        second_motor_channel_a_i,
    input  logic                        second_motor_channel_b_i,
    input  logic                        first_channel_direction_swap_i,
    input  logic                        second_channel_direction_swap_i,
    input  logic                        encoders_fitted_i,
    input  logic [desd_pkg::PCT_W-1:0]  error_speed_limit_i,
    input  logic [desd_pkg::PCT_W-1:0]  speed_demand_i,
    input  logic [desd_pkg::RES_W-1:0]  resolution_i,
    input  logic [desd_pkg::RPM_W-1:0]  rated_speed_i,
    input  logic [desd_pkg::COMP_W-1:0] compensation_i,
    output logic                        first_motor_channel_reverse_o,
    output logic                        second_motor_channel_reverse_o,
    output logic [desd_pkg::RPM_W-1:0]  first_motor_channel_rpm_o,
    output logic [desd_pkg::RPM_W-1:0]  second_motor_channel_rpm_o,
    output logic                        speed_valid_o,
    output logic                        encoder_error_o,
    output logic [desd_pkg::PCT_W-1:0]  speed_cap_o,
    output logic [desd_pkg::RPM_W-1:0]  target_rpm_o,
    output logic [desd_pkg::MOHM_W-1:0] compensation_mohm_o
);
    typedef enum logic {DIV_IDLE, DIV_RUN} desd_div_t;

    function automatic logic [15:0] desd_clamp(input logic [15:0] v,
                                               input logic [15:0] lo,
                                               input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : desd_clamp

    // Pin capture and per-channel decode
    logic [desd_pkg::PIN_W-1:0] raw_pins;
    logic [desd_pkg::PIN_W-1:0] pins_s;
    logic [desd_pkg::CHANS-1:0] swap_v;
    desd_pkg::desd_stat_t       stat [desd_pkg::CHANS];

    assign raw_pins[desd_pkg::PIN_A0] = first_motor_channel_a_i;
    assign raw_pins[desd_pkg::PIN_B0] = first_motor_channel_b_i;
    assign raw_pins[desd_pkg::PIN_A1] = second_motor_channel_a_i;
    assign raw_pins[desd_pkg::PIN_B1] = second_motor_channel_b_i;
    assign swap_v = {second_channel_direction_swap_i,
                     first_channel_direction_swap_i};

    desd_sync u_sync (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .pins_i     (raw_pins),
        .pins_o     (pins_s)
    );

    for (genvar i = 0; i < desd_pkg::CHANS; i++) begin : g_chan
        desd_pkg::desd_pins_t cp;
        assign cp.a = pins_s[desd_pkg::PIN_A0 + 2 * i];
        assign cp.b = pins_s[desd_pkg::PIN_B0 + 2 * i];
        desd_chan u_chan (
            .core_clk_i (core_clk_i),
            .sys_rst_i  (sys_rst_i),
            .pins_i     (cp),
            .swap_i     (swap_v[i]),
            .stat_o     (stat[i])
        );
    end

    // Measurement interval, edge counting and channel faults
    logic [desd_pkg::CNT_W-1:0]  meas_cnt;
    logic [desd_pkg::CNT_W-1:0]  next_meas_cnt;
    logic                        tick;
    logic [desd_pkg::EDGE_W-1:0] edge_cnt      [desd_pkg::CHANS];
    logic [desd_pkg::EDGE_W-1:0] next_edge_cnt [desd_pkg::CHANS];
    logic [desd_pkg::EDGE_W-1:0] snap;
    logic [desd_pkg::EDGE_W-1:0] next_snap;
    logic [desd_pkg::CHANS-1:0]  glitch_seen;
    logic [desd_pkg::CHANS-1:0]  next_glitch_seen;
    logic [desd_pkg::CHANS-1:0]  err_ch;
    logic [desd_pkg::CHANS-1:0]  next_err_ch;
    logic                        demand_active;

    always_comb begin
        tick          = (meas_cnt == desd_pkg::CNT_W'(MEAS_CYCLES - 1));
        next_meas_cnt = tick ? '0 : meas_cnt + 1'b1;
        demand_active = (speed_demand_i != desd_pkg::PCT_MIN);
        next_snap     = tick ? edge_cnt[1] : snap;
        for (int c = 0; c < desd_pkg::CHANS; c++) begin
            if (tick) begin
                next_edge_cnt[c] = desd_pkg::EDGE_W'(stat[c].edge_seen);
                next_glitch_seen[c] = stat[c].glitch;
            end else begin
                next_edge_cnt[c] = edge_cnt[c];
                if (stat[c].edge_seen && (edge_cnt[c] != '1)) begin
                    next_edge_cnt[c] = edge_cnt[c] + 1'b1;
                end
                next_glitch_seen[c] = glitch_seen[c] | stat[c].glitch;
            end
            // A new fault wins over a clear in the same cycle
            if (stat[c].glitch || (tick && demand_active
                                   && (edge_cnt[c] == '0))) begin
                next_err_ch[c] = 1'b1;
            end else if (tick && (edge_cnt[c] != '0)
                         && !glitch_seen[c]) begin
                next_err_ch[c] = 1'b0;
            end else begin
                next_err_ch[c] = err_ch[c];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            meas_cnt    <= '0;
            edge_cnt    <= '{default: '0};
            snap        <= '0;
            glitch_seen <= '0;
            err_ch      <= '0;
        end else begin
            meas_cnt    <= next_meas_cnt;
            edge_cnt    <= next_edge_cnt;
            snap        <= next_snap;
            glitch_seen <= next_glitch_seen;
            err_ch      <= next_err_ch;
        end
    end

    // Shared serial divider: rpm = edges * rpm_per_edge / resolution
    desd_div_t                   div_state;
    desd_div_t                   next_div_state;
    logic                        div_ch;
    logic                        next_div_ch;
    logic [desd_pkg::BIT_W-1:0]  div_bit;
    logic [desd_pkg::BIT_W-1:0]  next_div_bit;
    logic [desd_pkg::DIVD_W-1:0] divd;
    logic [desd_pkg::DIVD_W-1:0] next_divd;
    logic [desd_pkg::DIVD_W-1:0] quo;
    logic [desd_pkg::DIVD_W-1:0] next_quo;
    logic [desd_pkg::RES_W-1:0]  rem;
    logic [desd_pkg::RES_W-1:0]  next_rem;
    logic [desd_pkg::RES_W-1:0]  divisor;
    logic [desd_pkg::RES_W-1:0]  next_divisor;
    logic [desd_pkg::RES_W:0]    trial;
    logic [desd_pkg::RPM_W-1:0]  rpm_sat;
    logic [desd_pkg::RPM_W-1:0]  next_rpm0;
    logic [desd_pkg::RPM_W-1:0]  next_rpm1;
    logic                        next_speed_valid;
    logic                        div_last;
    logic                        quo_ready;
    logic                        div_done;
    logic                        next_quo_ready;
    logic                        next_div_done;

    always_comb begin
        next_div_state   = div_state;
        next_div_ch      = div_ch;
        next_div_bit     = div_bit;
        next_divd        = divd;
        next_quo         = quo;
        next_rem         = rem;
        next_divisor     = divisor;
        next_rpm0        = first_motor_channel_rpm_o;
        next_rpm1        = second_motor_channel_rpm_o;
        next_speed_valid = 1'b0;
        trial    = {rem, divd[desd_pkg::DIVD_W-1]};
        div_last = (div_bit == desd_pkg::BIT_W'(desd_pkg::DIVD_W - 1));
        rpm_sat  = (quo[desd_pkg::DIVD_W-1:desd_pkg::RPM_W] != '0) ? '1
                   : quo[desd_pkg::RPM_W-1:0];
        unique case (div_state)
            DIV_IDLE: begin
                if (tick) begin
                    next_div_state = DIV_RUN;
                    next_div_ch    = 1'b0;
                    next_div_bit   = '0;
                    next_rem       = '0;
                    next_divd      = desd_pkg::DIVD_W'(edge_cnt[0]
                                     * desd_pkg::RPM_PER_EDGE);
                    next_divisor   = desd_pkg::RES_W'(desd_clamp(
                                     16'(resolution_i),
                                     16'(desd_pkg::RES_MIN),
                                     16'(desd_pkg::RES_MAX)));
                end
            end
            DIV_RUN: begin
                next_divd    = {divd[desd_pkg::DIVD_W-2:0], 1'b0};
                next_div_bit = div_bit + 1'b1;
                if (trial >= {1'b0, divisor}) begin
                    next_rem = desd_pkg::RES_W'(trial - {1'b0, divisor});
                    next_quo = {quo[desd_pkg::DIVD_W-2:0], 1'b1};
                end else begin
                    next_rem = trial[desd_pkg::RES_W-1:0];
                    next_quo = {quo[desd_pkg::DIVD_W-2:0], 1'b0};
                end
                if (div_last) begin
                    next_div_bit = '0;
                    next_rem     = '0;
                    if (!div_ch) begin
                        next_div_ch = 1'b1;
                        next_divd   = desd_pkg::DIVD_W'(snap
                                      * desd_pkg::RPM_PER_EDGE);
                    end else begin
                        next_div_state = DIV_IDLE;
                    end
                end
            end
        endcase
        // Result of the previous pass is complete one cycle after it ends
        if (div_state == DIV_RUN && div_bit == '0 && div_ch
            && quo_ready) begin
            next_rpm0 = rpm_sat;
        end
        if (div_done) begin
            next_rpm1        = rpm_sat;
            next_speed_valid = 1'b1;
        end
    end

    always_comb begin
        next_quo_ready = (div_state == DIV_RUN) && div_last && !div_ch;
        next_div_done  = (div_state == DIV_RUN) && div_last && div_ch;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            div_state                  <= DIV_IDLE;
            div_ch                     <= 1'b0;
            div_bit                    <= '0;
            divd                       <= '0;
            quo                        <= '0;
            rem                        <= '0;
            divisor                    <= desd_pkg::RES_MIN;
            quo_ready                  <= 1'b0;
            div_done                   <= 1'b0;
            first_motor_channel_rpm_o  <= desd_pkg::RST_RPM;
            second_motor_channel_rpm_o <= desd_pkg::RST_RPM;
            speed_valid_o              <= 1'b0;
        end else begin
            div_state                  <= next_div_state;
            div_ch                     <= next_div_ch;
            div_bit                    <= next_div_bit;
            divd                       <= next_divd;
            quo                        <= next_quo;
            rem                        <= next_rem;
            divisor                    <= next_divisor;
            quo_ready                  <= next_quo_ready;
            div_done                   <= next_div_done;
            first_motor_channel_rpm_o  <= next_rpm0;
            second_motor_channel_rpm_o <= next_rpm1;
            speed_valid_o              <= next_speed_valid;
        end
    end

    // Error, speed cap, target speed and compensation outputs
    logic [desd_pkg::PCT_W-1:0]  lim_pct;
    logic [desd_pkg::PCT_W-1:0]  dem_pct;
    logic [desd_pkg::RPM_W-1:0]  rated_eff;
    logic [desd_pkg::COMP_W-1:0] comp_code;
    logic                        next_error;
    logic [desd_pkg::PCT_W-1:0]  next_cap;
    logic [desd_pkg::RPM_W-1:0]  next_target;
    logic [desd_pkg::MOHM_W-1:0] next_mohm;
    logic [desd_pkg::TGT_W-1:0]  tgt_prod;

    always_comb begin
        lim_pct   = desd_pkg::PCT_W'(desd_clamp(16'(error_speed_limit_i),
                    16'(desd_pkg::PCT_MIN), 16'(desd_pkg::PCT_FULL)));
        dem_pct   = desd_pkg::PCT_W'(desd_clamp(16'(speed_demand_i),
                    16'(desd_pkg::PCT_MIN), 16'(desd_pkg::PCT_FULL)));
        rated_eff = desd_pkg::RPM_W'(desd_clamp(16'(rated_speed_i),
                    16'(desd_pkg::RATED_MIN),
                    16'(desd_pkg::RATED_MAX)));
        comp_code = desd_pkg::COMP_W'(desd_clamp(16'(compensation_i),
                    16'h0000, 16'(desd_pkg::COMP_MAX_CODE)));
        next_error = encoders_fitted_i && (err_ch != '0);
        next_cap   = dem_pct;
        if (encoder_error_o && (dem_pct > lim_pct)) begin
            next_cap = lim_pct;
        end
        tgt_prod = desd_pkg::TGT_W'(speed_cap_o)
                   * desd_pkg::TGT_W'(rated_eff)
                   * desd_pkg::TGT_W'(desd_pkg::FULL_NUM)
                   / desd_pkg::TGT_W'(desd_pkg::FULL_DEN
                                      * desd_pkg::PCT_FULL);
        next_target = tgt_prod[desd_pkg::RPM_W-1:0];
        next_mohm   = desd_pkg::MOHM_W'(comp_code)
                      * desd_pkg::COMP_STEP_MOHM;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            encoder_error_o                <= 1'b0;
            speed_cap_o                    <= desd_pkg::RST_PCT;
            target_rpm_o                   <= desd_pkg::RST_RPM;
            compensation_mohm_o            <= desd_pkg::RST_MOHM;
            first_motor_channel_reverse_o  <= 1'b0;
            second_motor_channel_reverse_o <= 1'b0;
        end else begin
            encoder_error_o                <= next_error;
            speed_cap_o                    <= next_cap;
            target_rpm_o                   <= next_target;
            compensation_mohm_o            <= next_mohm;
            first_motor_channel_reverse_o  <= stat[0].reverse;
            second_motor_channel_reverse_o <= stat[1].reverse;
        end
    end

    chk_err_unfitted: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !encoders_fitted_i |=> !encoder_error_o)
        else $error("encoder error raised while not fitted");

    chk_err_fitted: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (encoders_fitted_i && (err_ch != '0)) |=> encoder_error_o)
        else $error("encoder fault not reported");

    chk_cap_limit: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        encoder_error_o |=> (speed_cap_o <= $past(lim_pct)))
        else $error("speed above error limit");

    chk_cap_free: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        !encoder_error_o |=> (speed_cap_o == $past(dem_pct)))
        else $error("speed capped without error");

    chk_res_range: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (div_state == DIV_RUN) |-> (divisor >= desd_pkg::RES_MIN
                                    && divisor <= desd_pkg::RES_MAX))
        else $error("resolution out of range");

    chk_rated_range: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        $stable(rated_speed_i) |=> (target_rpm_o <= desd_pkg::RATED_MAX))
        else $error("target above rated range");

    chk_target_full: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (speed_cap_o == desd_pkg::PCT_FULL) |=> (32'(target_rpm_o)
            == 32'($past(rated_eff)) * desd_pkg::FULL_NUM
               / desd_pkg::FULL_DEN))
        else $error("full speed target wrong");

    chk_comp_step: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        1'b1 |=> (32'(compensation_mohm_o) == 32'($past(comp_code)) * 5
                  && compensation_mohm_o <= 9'h1f4))
        else $error("compensation value wrong");

    chk_interval_speed: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (tick && div_state == DIV_IDLE) |-> ##[1:50] speed_valid_o)
        else $error("speed result late");
endmodule : desd_top

/* File: shared/desd_pkg.sv */
// Constants and carrier types for the dual encoder speed and direction block.
// Assumes a single 10 MHz core clock and a synchronous active-high reset.
package desd_pkg;

    // Clock and measurement timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int MEAS_TIME_MS  = 100;
    localparam int MEAS_CYCLES   = MEAS_TIME_MS * (CLK_HZ / 1000);
    localparam int CNT_W         = 20;

    // Encoder pin vector layout
    localparam int CHANS         = 2;
    localparam int PIN_W         = 4;
    localparam int PIN_A0        = 0;
    localparam int PIN_B0        = 1;
    localparam int PIN_A1        = 2;
    localparam int PIN_B1        = 3;

    // Percentages
    localparam int PCT_W         = 7;
    localparam logic [6:0] PCT_MIN  = 7'h00;
    localparam logic [6:0] PCT_FULL = 7'h64;

    // Encoder resolution in pulses per revolution
    localparam int RES_W         = 8;
    localparam logic [7:0] RES_MIN  = 8'h01;
    localparam logic [7:0] RES_MAX  = 8'h80;

    // Motor speeds in rpm
    localparam int RPM_W         = 14;
    localparam logic [13:0] RATED_MIN = 14'h0096;
    localparam logic [13:0] RATED_MAX = 14'h262f;

    // Compensation resistance: code times step gives milliohms
    localparam int COMP_W        = 7;
    localparam int MOHM_W        = 9;
    localparam logic [6:0] COMP_MAX_CODE  = 7'h64;
    localparam logic [8:0] COMP_STEP_MOHM = 9'h005;

    // Speed arithmetic
    localparam int EDGE_W        = 12;
    localparam int RPM_PER_EDGE  = 60 * 1000 / MEAS_TIME_MS;
    localparam int DIVD_W        = 22;
    localparam int BIT_W         = 5;
    localparam int TGT_W         = 28;
    localparam int FULL_NUM      = 216;
    localparam int FULL_DEN      = 240;

    // Reset values
    localparam logic [13:0] RST_RPM  = 14'h0000;
    localparam logic [6:0]  RST_PCT  = 7'h00;
    localparam logic [8:0]  RST_MOHM = 9'h000;

    typedef struct packed {
        logic a;
        logic b;
    } desd_pins_t;

    typedef struct packed {
        logic reverse;
        logic edge_seen;
        logic glitch;
    } desd_stat_t;

endpackage : desd_pkg

/* File: hdl/desd_sync.sv */
// Two-stage synchroniser for the four encoder pins.
// Assumes the pins are asynchronous to core_clk_i.
`timescale 1ns/100ps
module desd_sync (
    input  logic                      core_clk_i,
    input  logic                      sys_rst_i,
    input  logic [desd_pkg::PIN_W-1:0] pins_i,
    output logic [desd_pkg::PIN_W-1:0] pins_o
);
    logic [desd_pkg::PIN_W-1:0] meta;
    logic [desd_pkg::PIN_W-1:0] next_meta;
    logic [desd_pkg::PIN_W-1:0] next_pins;

    always_comb begin
        next_meta = pins_i;
        next_pins = meta;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            meta   <= '0;
            pins_o <= '0;
        end else begin
            meta   <= next_meta;
            pins_o <= next_pins;
        end
    end
endmodule : desd_sync

/* File: hdl/desd_chan.sv */
// Direction decoder for one encoder channel.
// Assumes synchronised A and B pins and a swap setting from core logic.
`timescale 1ns/100ps
module desd_chan (
    input  logic                 core_clk_i,
    input  logic                 sys_rst_i,
    input  desd_pkg::desd_pins_t pins_i,
    input  logic                 swap_i,
    output desd_pkg::desd_stat_t stat_o
);
    desd_pkg::desd_pins_t prev;
    desd_pkg::desd_pins_t next_prev;
    logic                 primed;
    logic                 next_primed;
    desd_pkg::desd_stat_t next_stat;
    logic                 rise;
    logic                 dir_sample;
    logic [1:0]           warm;
    logic [1:0]           next_warm;

    always_comb begin
        next_prev   = pins_i;
        // Compare only once the synchroniser and prev hold real pin samples
        next_warm   = {warm[0], 1'b1};
        next_primed = warm[1];
        rise        = primed && pins_i.a && !prev.a;
        dir_sample  = pins_i.b ^ swap_i;
        next_stat.edge_seen = rise;
        next_stat.reverse   = rise ? dir_sample : stat_o.reverse;
        next_stat.glitch    = primed && (pins_i.a != prev.a)
                              && (pins_i.b != prev.b);
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            prev   <= '0;
            primed <= 1'b0;
            warm   <= '0;
            stat_o <= '0;
        end else begin
            prev   <= next_prev;
            primed <= next_primed;
            warm   <= next_warm;
            stat_o <= next_stat;
        end
    end

    chk_fwd_decode: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (rise && !swap_i) |=> (stat_o.reverse == $past(pins_i.b)))
        else $error("direction wrong without swap");

    chk_swap_decode: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        (rise && swap_i) |=> (stat_o.reverse == !$past(pins_i.b)))
        else $error("direction wrong with swap");
endmodule : desd_chan

/* File: hdl/_unused_placeholder_removed.sv */
// Intentionally empty file holder for build order; contains no logic.
// Assumes nothing.

/* File: testbench/desd_enc_model.sv */
// Quadrature encoder model for one motor channel.
// Assumes the bench clock; one quarter of a cycle lasts QTR clocks.
`timescale 1ns/100ps
module desd_enc_model #(
    parameter int QTR = 5
) (
    input  logic core_clk_i,
    input  logic run_i,
    input  logic rev_i,
    output logic a_o,
    output logic b_o
);
    int         cnt = 0;
    logic [1:0] ph  = 2'h0;
    // Steps on the falling edge, holds levels while stopped
    always @(negedge core_clk_i) begin
        if (run_i) begin
            cnt = cnt + 1;
            if (cnt >= QTR) begin
                cnt = 0;
                ph  = rev_i ? ph - 2'h1 : ph + 2'h1;
            end
        end
    end
    assign a_o = ph[1] ^ ph[0];
    assign b_o = ph[1];
endmodule : desd_enc_model

/* File: testbench/dual_encoder_speed_direction_tb_top.sv */
// Bench for the dual encoder block with two encoder models.
// Assumes MEAS_CYCLES of 200 so that each interval holds whole periods.
`timescale 1ns/100ps
module dual_encoder_speed_direction_tb_top;
    logic clk = 1'b0, rst = 1'b1, a0, b0, a1, b1, rev_o0, rev_o1, vld, err;
    logic run0 = 1'b1, run1 = 1'b1, rv0 = 1'b0, rv1 = 1'b1;
    logic sw0 = 1'b0, sw1 = 1'b0, fit = 1'b0;
    logic [6:0]  lim = 7'h1e, dem = 7'h50, comp = 7'h64, cap;
    logic [7:0]  res = 8'h20;
    logic [13:0] rated = 14'h03e8, rpm0, rpm1, tgt;
    logic [8:0]  mohm;
    int          n_mismatch = 0, cmp_count = 0;
    desd_enc_model #(.QTR(5))  i_enc0 (.core_clk_i(clk), .run_i(run0),
        .rev_i(rv0), .a_o(a0), .b_o(b0));
    desd_enc_model #(.QTR(10)) i_enc1 (.core_clk_i(clk), .run_i(run1),
        .rev_i(rv1), .a_o(a1), .b_o(b1));
    desd_top #(.MEAS_CYCLES(200)) i_dut (.core_clk_i(clk), .sys_rst_i(rst),
        .first_motor_channel_a_i(a0), .first_motor_channel_b_i(b0),
        .second_motor_channel_a_i(a1), .second_motor_channel_b_i(b1),
        .first_channel_direction_swap_i(sw0),
        .second_channel_direction_swap_i(sw1), .encoders_fitted_i(fit),
        .error_speed_limit_i(lim), .speed_demand_i(dem), .resolution_i(res),
        .rated_speed_i(rated), .compensation_i(comp),
        .first_motor_channel_reverse_o(rev_o0),
        .second_motor_channel_reverse_o(rev_o1),
        .first_motor_channel_rpm_o(rpm0), .second_motor_channel_rpm_o(rpm1),
        .speed_valid_o(vld), .encoder_error_o(err), .speed_cap_o(cap),
        .target_rpm_o(tgt), .compensation_mohm_o(mohm));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk
    task automatic wait_valid(input int n);
        int i;
        repeat (n) begin
            for (i = 0; i < 400; i++) begin
                @(posedge clk);
                #1;
                if (vld === 1'b1) break;
            end
            chk("speed_valid", 16'h1, {15'h0, vld});
        end
        @(negedge clk);
    endtask : wait_valid
    task automatic t_dir_speed();
        wait_valid(3);
        chk("rev0", 16'h0, rev_o0);
        chk("rev1", 16'h1, rev_o1);
        chk("rpm0", 16'd187, rpm0);
        chk("rpm1", 16'd93, rpm1);
        sw0 = 1'b1;
        sw1 = 1'b1;
        res = 8'h80;
        wait_valid(2);
        chk("rev0_swap", 16'h1, rev_o0);
        chk("rev1_swap", 16'h0, rev_o1);
        chk("rpm0_128", 16'd46, rpm0);
        chk("rpm1_128", 16'd23, rpm1);
        chk("err_unfit", 16'h0, err);
    endtask : t_dir_speed
    task automatic t_error();
        run0 = 1'b0;
        run1 = 1'b0;
        fit = 1'b1;
        wait_valid(2);
        repeat (3) @(negedge clk);
        chk("err", 16'h1, err);
        chk("cap", 16'd30, cap);
        chk("target_cap", 16'd270, tgt);
        fit = 1'b0;
        repeat (3) @(negedge clk);
        chk("err_off", 16'h0, err);
        chk("cap_off", 16'd80, cap);
        chk("target", 16'd720, tgt);
        chk("mohm", 16'd500, mohm);
        dem = 7'h64;
        repeat (3) @(negedge clk);
        chk("cap_full", 16'd100, cap);
        chk("target_full", 16'd900, tgt);
    endtask : t_error
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_dir_speed();
        t_error();
        tally_and_finish();
    end
endmodule : dual_encoder_speed_direction_tb_top
